/* File: common/hsl_pkg.sv */
// Shared constants and types of the homing sequencer.
`default_nettype none
package hsl_pkg;

  // Homing method codes accepted on the mode input.
  localparam logic [5:0] HSL_MODE_24 = 6'h18;
  localparam logic [5:0] HSL_MODE_25 = 6'h19;
  localparam logic [5:0] HSL_MODE_26 = 6'h1A;
  localparam logic [5:0] HSL_MODE_27 = 6'h1B;

  // Bit positions of the sensed switches in the edge vectors.
  localparam int HSL_SENSE_W = 3;
  localparam int HSL_HOME    = 0;
  localparam int HSL_POS_LIM = 1;
  localparam int HSL_NEG_LIM = 2;

  // Direction codes on move_dir.
  localparam logic HSL_DIR_POS = 1'b1;
  localparam logic HSL_DIR_NEG = 1'b0;

  // Reset value of the sampled switch levels.
  localparam logic [HSL_SENSE_W-1:0] HSL_SENSE_RST = 3'h0;

  typedef enum logic [2:0] {
    HSL_IDLE  = 3'b000,
    HSL_FAST  = 3'b001,
    HSL_BACK  = 3'b010,
    HSL_SLOW  = 3'b011,
    HSL_HALT  = 3'b100,
    HSL_HOMED = 3'b101,
    HSL_ABORT = 3'b110
  } hsl_state_t;

endpackage : hsl_pkg
`default_nettype wire

/* File: common/hsl_edge_if.sv */
// Sampled switch levels and their edges, passed to the sequencer.
`timescale 1ns/100ps
`default_nettype none
interface hsl_edge_if;
  logic [hsl_pkg::HSL_SENSE_W-1:0] level;
  logic [hsl_pkg::HSL_SENSE_W-1:0] rise;
  logic [hsl_pkg::HSL_SENSE_W-1:0] fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : hsl_edge_if
`default_nettype wire

/* File: rtl/hsl_edge_detect.sv */
// Samples the switch inputs and marks their transitions.
`timescale 1ns/100ps
`default_nettype none
module hsl_edge_detect #(
  parameter int W = hsl_pkg::HSL_SENSE_W
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // Raw switch levels
  input  wire logic [W-1:0] sample,
  // Levels and edges
  hsl_edge_if.src           edges
);

  logic [W-1:0] cur;
  logic [W-1:0] prev;

  // Two registered samples are compared so that every edge is a clean
  // one-cycle pulse aligned with the level the sequencer sees.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cur  <= hsl_pkg::HSL_SENSE_RST;
      prev <= hsl_pkg::HSL_SENSE_RST;
    end else begin
      cur  <= sample;
      prev <= cur;
    end
  end

  assign edges.level = cur;
  assign edges.rise  = cur & ~prev;
  assign edges.fall  = ~cur & prev;

endmodule : hsl_edge_detect
`default_nettype wire

/* File: rtl/hsl_homing_seq.sv */
// Homing sequencer for switch-edge methods with one limit reversal.
`timescale 1ns/100ps
`default_nettype none
module hsl_homing_seq (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Command
  input  wire logic       start,
  input  wire logic [5:0] mode,
  // Switches, high while on
  input  wire logic       home_switch,
  input  wire logic       positive_limit,
  input  wire logic       negative_limit,
  // Motion profile
  input  wire logic       stop_done,
  output logic            move_req,
  output logic            move_dir,
  output logic            move_fast,
  output logic            stop_req,
  // Status
  output logic            home_found,
  output logic            alarm,
  output logic            busy
);

  hsl_edge_if ev ();

  hsl_edge_detect #(
    .W (hsl_pkg::HSL_SENSE_W)
  ) u_edges (
    .clock  (clock),
    .rstn   (rstn),
    .sample ({negative_limit, positive_limit, home_switch}),
    .edges  (ev.src)
  );

  hsl_pkg::hsl_state_t st;
  hsl_pkg::hsl_state_t resume;
  logic                resume_dir;
  logic                dir;
  logic                limit_seen;
  logic [5:0]          mode_q;

  logic mode_ok;
  logic start_dir;
  logic tgt_rise;
  logic final_dir;
  logic own_dir;
  logic tgt_edge;
  logic other_edge;
  logic own_hit;
  logic far_hit;
  logic moving;
  logic abort;

  // Start direction depends on the method and on the switch at start.
  always_comb begin
    mode_ok   = 1'b1;
    start_dir = hsl_pkg::HSL_DIR_POS;
    case (mode)
      hsl_pkg::HSL_MODE_24: begin
        start_dir = !ev.level[hsl_pkg::HSL_HOME];
      end
      hsl_pkg::HSL_MODE_25: begin
        start_dir = hsl_pkg::HSL_DIR_POS;
      end
      hsl_pkg::HSL_MODE_26: begin
        start_dir = hsl_pkg::HSL_DIR_POS;
      end
      hsl_pkg::HSL_MODE_27: begin
        start_dir = ev.level[hsl_pkg::HSL_HOME];
      end
      default: begin
        mode_ok = 1'b0;
      end
    endcase
  end

  // Per-method shape: the edge that marks home, the final approach
  // direction and the end of travel that allows one reversal.
  assign tgt_rise  = (mode_q == hsl_pkg::HSL_MODE_24) ||
                     (mode_q == hsl_pkg::HSL_MODE_25);
  assign final_dir = (mode_q != hsl_pkg::HSL_MODE_25);
  assign own_dir   = (mode_q != hsl_pkg::HSL_MODE_27);

  assign tgt_edge   = tgt_rise ? ev.rise[hsl_pkg::HSL_HOME]
                               : ev.fall[hsl_pkg::HSL_HOME];
  assign other_edge = tgt_rise ? ev.fall[hsl_pkg::HSL_HOME]
                               : ev.rise[hsl_pkg::HSL_HOME];
  assign own_hit = own_dir ? ev.rise[hsl_pkg::HSL_POS_LIM]
                           : ev.rise[hsl_pkg::HSL_NEG_LIM];
  assign far_hit = own_dir ? ev.rise[hsl_pkg::HSL_NEG_LIM]
                           : ev.rise[hsl_pkg::HSL_POS_LIM];

  assign moving = (st == hsl_pkg::HSL_FAST) || (st == hsl_pkg::HSL_BACK) ||
                  (st == hsl_pkg::HSL_SLOW);
  // Only the first own-side limit met in the fast search, while heading
  // towards it, is forgiven; any other limit contact ends the run.
  assign abort = moving && (far_hit || (own_hit && (limit_seen ||
                 st != hsl_pkg::HSL_FAST || dir != own_dir)));

  // Sequencing of the motion phases.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st         <= hsl_pkg::HSL_IDLE;
      resume     <= hsl_pkg::HSL_IDLE;
      resume_dir <= hsl_pkg::HSL_DIR_POS;
      dir        <= hsl_pkg::HSL_DIR_POS;
      limit_seen <= 1'b0;
      mode_q     <= hsl_pkg::HSL_MODE_24;
    end else begin
      case (st)
        hsl_pkg::HSL_IDLE: begin
          if (start) begin
            mode_q     <= mode;
            limit_seen <= 1'b0;
            dir        <= start_dir;
            st <= mode_ok ? hsl_pkg::HSL_FAST : hsl_pkg::HSL_ABORT;
          end
        end
        hsl_pkg::HSL_FAST: begin
          if (abort) begin
            st <= hsl_pkg::HSL_ABORT;
          end else if (own_hit) begin
            limit_seen <= 1'b1;
            st         <= hsl_pkg::HSL_HALT;
            resume     <= hsl_pkg::HSL_FAST;
            resume_dir <= !dir;
          end else if (dir == final_dir && tgt_edge) begin
            st         <= hsl_pkg::HSL_HALT;
            resume     <= hsl_pkg::HSL_BACK;
            resume_dir <= !dir;
          end else if (dir != final_dir && other_edge) begin
            st         <= hsl_pkg::HSL_HALT;
            resume     <= hsl_pkg::HSL_SLOW;
            resume_dir <= final_dir;
          end
        end
        hsl_pkg::HSL_BACK: begin
          if (abort) begin
            st <= hsl_pkg::HSL_ABORT;
          end else if (other_edge) begin
            // Overshoot of a narrow switch region is harmless here: the
            // slow approach that follows heads back towards the edge.
            st         <= hsl_pkg::HSL_HALT;
            resume     <= hsl_pkg::HSL_SLOW;
            resume_dir <= final_dir;
          end
        end
        hsl_pkg::HSL_SLOW: begin
          if (abort) begin
            st <= hsl_pkg::HSL_ABORT;
          end else if (tgt_edge) begin
            st <= hsl_pkg::HSL_HOMED;
          end
        end
        hsl_pkg::HSL_HALT: begin
          if (stop_done) begin
            st  <= resume;
            dir <= resume_dir;
          end
        end
        hsl_pkg::HSL_HOMED: begin
          if (stop_done) begin
            st <= hsl_pkg::HSL_IDLE;
          end
        end
        hsl_pkg::HSL_ABORT: begin
          if (stop_done) begin
            st <= hsl_pkg::HSL_IDLE;
          end
        end
        default: begin
          st <= hsl_pkg::HSL_IDLE;
        end
      endcase
    end
  end

  // Home strobe: the profile latches its stop position on this pulse.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      home_found <= 1'b0;
    end else begin
      home_found <= (st == hsl_pkg::HSL_HOMED) && stop_done;
    end
  end

  // Alarm holds until the next start so software sees why motion ended.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      alarm <= 1'b0;
    end else if ((moving && abort) ||
                 (st == hsl_pkg::HSL_IDLE && start && !mode_ok)) begin
      alarm <= 1'b1;
    end else if (st == hsl_pkg::HSL_IDLE && start) begin
      alarm <= 1'b0;
    end
  end

  assign move_req  = moving;
  assign move_dir  = dir;
  assign move_fast = (st == hsl_pkg::HSL_FAST) || (st == hsl_pkg::HSL_BACK);
  assign stop_req  = (st == hsl_pkg::HSL_HALT) ||
                     (st == hsl_pkg::HSL_HOMED) ||
                     (st == hsl_pkg::HSL_ABORT);
  assign busy      = (st != hsl_pkg::HSL_IDLE);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_halt_waits_done: assert property (
    st == hsl_pkg::HSL_HALT && !stop_done |=> st == hsl_pkg::HSL_HALT &&
      stop_req && !move_req)
    else $error("halt left before the stop completed");

  a_halt_resumes: assert property (
    st == hsl_pkg::HSL_HALT && stop_done |=> st == $past(resume) &&
      move_dir == $past(resume_dir))
    else $error("halt did not resume the planned phase");

  a_home_stop: assert property (
    st == hsl_pkg::HSL_SLOW && tgt_edge && !abort |=>
      st == hsl_pkg::HSL_HOMED && stop_req && !move_req && !home_found)
    else $error("target edge did not stop the slow approach");

  a_home_strobe: assert property (
    st == hsl_pkg::HSL_HOMED && stop_done |=> home_found && !busy)
    else $error("home strobe missing after the final stop");

  a_strobe_source: assert property (
    home_found |-> $past(st) == hsl_pkg::HSL_HOMED && $past(stop_done))
    else $error("home strobe without a completed final stop");

  a_far_limit_abort: assert property (
    moving && far_hit |=> alarm && st == hsl_pkg::HSL_ABORT)
    else $error("opposite limit did not abort");

  a_second_limit: assert property (
    moving && own_hit && limit_seen |=> alarm && stop_req)
    else $error("second limit hit did not abort");

  a_first_reversal: assert property (
    st == hsl_pkg::HSL_FAST && own_hit && !abort |=>
      st == hsl_pkg::HSL_HALT && resume == hsl_pkg::HSL_FAST &&
      resume_dir != $past(dir) && limit_seen && !alarm)
    else $error("first limit hit did not reverse");

  a_retreat_planned: assert property (
    st == hsl_pkg::HSL_FAST && !own_hit && !abort && dir == final_dir &&
      tgt_edge |=> resume == hsl_pkg::HSL_BACK && resume_dir != final_dir)
    else $error("target edge at speed did not plan a retreat");

  a_slow_direction: assert property (
    st == hsl_pkg::HSL_SLOW |-> move_dir == final_dir && !move_fast)
    else $error("slow approach in wrong direction");

  a_start_direction: assert property (
    st == hsl_pkg::HSL_IDLE && start && mode_ok |=>
      st == hsl_pkg::HSL_FAST && move_dir == $past(start_dir) && move_fast)
    else $error("search began in wrong direction");

endmodule : hsl_homing_seq
`default_nettype wire

/* File: verification/hsl_axis_model.sv */
// Behavioural axis: home switch, end limits and stop profile.
`timescale 1ns/100ps
`default_nettype none
module hsl_axis_model #(
  parameter int HOME_LO = 40,
  parameter int HOME_HI = 60,
  parameter int LIMIT   = 150
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rstn,
  // Test control
  input  wire logic               load,
  input  wire logic signed [15:0] load_pos,
  input  wire logic               no_home,
  // Motion requests
  input  wire logic               move_req,
  input  wire logic               move_dir,
  input  wire logic               move_fast,
  input  wire logic               stop_req,
  output logic                    stop_done,
  // Sensed axis
  output logic signed [15:0]      pos,
  output logic                    home_switch,
  output logic                    positive_limit,
  output logic                    negative_limit
);
  logic [1:0]  stop_cnt;
  logic [15:0] step;
  assign step = move_fast ? 16'h0002 : 16'h0001;
  always_ff @(posedge clock) begin
    if (!rstn || load) pos <= load_pos;
    else if (move_req) pos <= move_dir ? pos + step : pos - step;
  end
  // A stop takes several cycles, so an early move would show up.
  always_ff @(posedge clock) begin
    if (!rstn || !stop_req) stop_cnt <= 2'h0;
    else if (stop_cnt != 2'h3) stop_cnt <= stop_cnt + 2'h1;
  end
  assign stop_done = stop_req && stop_cnt == 2'h3;
  assign home_switch = !no_home && pos >= HOME_LO && pos <= HOME_HI;
  assign positive_limit = pos >= LIMIT;
  assign negative_limit = pos <= -LIMIT;
endmodule : hsl_axis_model
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the homing sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic               clock, rstn, start, load, no_home;
  logic [5:0]         mode;
  logic signed [15:0] load_pos, pos;
  logic               home_switch, positive_limit, negative_limit;
  logic               stop_done, move_req, move_dir, move_fast;
  logic               stop_req, home_found, alarm, busy;
  int                 fail_count, samples_checked;

  hsl_homing_seq dut_u (.clock, .rstn, .start, .mode, .home_switch,
    .positive_limit, .negative_limit, .stop_done, .move_req, .move_dir,
    .move_fast, .stop_req, .home_found, .alarm, .busy);
  hsl_axis_model axis_u (.clock, .rstn, .load, .load_pos, .no_home,
    .move_req, .move_dir, .move_fast, .stop_req, .stop_done, .pos,
    .home_switch, .positive_limit, .negative_limit);

  always #5 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // Places the axis, starts homing and follows it until idle.
  task automatic home_run(input logic [5:0] m, input logic signed [15:0] p,
                          input logic nh, output logic hf,
                          output logic signed [15:0] hp);
    int n;
    @(posedge clock);
    load <= 1'b1;
    load_pos <= p;
    no_home <= nh;
    @(posedge clock);
    load <= 1'b0;
    repeat (3) @(posedge clock);
    start <= 1'b1;
    mode <= m;
    @(posedge clock);
    start <= 1'b0;
    hf = 1'b0;
    hp = 16'sh0000;
    for (n = 0; n < 2000; n++) begin
      @(negedge clock);
      if (home_found === 1'b1) begin
        hf = 1'b1;
        hp = pos;
      end
      if (busy === 1'b0) break;
    end
    if (n == 2000) begin
      fail_count++;
      $display("wrong value at %0t: homing never ended", $time);
      close_out();
    end
  endtask : home_run

  // Without a home switch methods 24, 25 and 27 each end on a forbidden limit; the unknown code 6'h17 aborts at start.
  task automatic abort_cases();
    logic [5:0]         ms [4];
    logic signed [15:0] ps [4];
    logic               hf;
    logic signed [15:0] hp;
    ms = '{hsl_pkg::HSL_MODE_24, hsl_pkg::HSL_MODE_25,
           hsl_pkg::HSL_MODE_27, 6'h17};
    ps = '{16'sh0064, 16'sh0000, 16'sh0000, 16'sh0000};
    for (int i = 0; i < 4; i++) begin
      home_run(ms[i], ps[i], 1'b1, hf, hp);
      check({15'h0000, alarm}, 16'h0001, "alarm after abort");
      check({15'h0000, hf}, 16'h0000, "home after abort");
    end
    $display("test abort_cases done");
  endtask : abort_cases

  // Every method from both sides of the switch and from inside it.
  task automatic all_methods();
    logic signed [15:0] ps [3];
    logic [5:0]         m;
    logic               hf, up;
    logic signed [15:0] hp, e, d;
    logic [15:0]        hok;
    ps = '{16'sh0064, 16'sh0000, 16'sh0032};
    for (int i = 0; i < 12; i++) begin
      m = hsl_pkg::HSL_MODE_24 + 6'(i / 3);
      home_run(m, ps[i % 3], 1'b0, hf, hp);
      e = (m == hsl_pkg::HSL_MODE_24) ? 16'sh0028 : 16'sh003C;
      up = (m != hsl_pkg::HSL_MODE_25);
      d = up ? hp - e : e - hp;
      hok = {15'h0000, d >= 0 && d <= 4};
      check({15'h0000, alarm}, 16'h0000, "alarm on good run");
      check({15'h0000, hf}, 16'h0001, "home found");
      check({14'h0000, move_req, stop_req}, 16'h0000, "idle motion");
      case (m)
        hsl_pkg::HSL_MODE_24: check(hok, 16'h0001, "home");
        hsl_pkg::HSL_MODE_25: check(hok, 16'h0001, "home");
        hsl_pkg::HSL_MODE_26: check(hok, 16'h0001, "home");
        default: check(hok, 16'h0001, "home");
      endcase
    end
    $display("test all_methods done");
  endtask : all_methods

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    start = 1'b0;
    mode = 6'h00;
    load = 1'b0;
    load_pos = 16'sh0000;
    no_home = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    abort_cases();
    all_methods();
    close_out();
  end
endmodule : tb
`default_nettype wire
